// ==== fsp_cfg.svh ====
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Link opcodes
`define FSP_OP_STATUS_READ     8'h05
`define FSP_OP_WRITE_ENABLE    8'h06
`define FSP_OP_WRITE_DISABLE   8'h04
`define FSP_OP_STATUS_UNLOCK   8'h50
`define FSP_OP_STATUS_WRITE    8'h01

////////////////////////////////////////////////////////////////////////////////
// Status register field positions and reset values
`define FSP_BIT_PROT_LO        2
`define FSP_BIT_PROT_HI        4
`define FSP_BIT_LOCK           7
`define FSP_RST_PROT           3'h7
`define FSP_RST_LOCK           1'h0
`define FSP_RST_LATCH          1'h0
`define FSP_PROT_NONE          3'h0

////////////////////////////////////////////////////////////////////////////////
// Event toggle indices, link to system
`define FSP_EV_WR_ENABLE       0
`define FSP_EV_WR_DISABLE      1
`define FSP_EV_UNLOCK          2
`define FSP_EV_STAT_WRITE      3

////////////////////////////////////////////////////////////////////////////////
// Protected ranges per density: top of array, then range bases
`define FSP_FULL_BASE          24'h000000
`define FSP_TOP_512K           24'h00FFFF
`define FSP_Q_512K             24'h00C000
`define FSP_H_512K             24'h008000
`define FSP_TOP_1M             24'h01FFFF
`define FSP_Q_1M               24'h018000
`define FSP_H_1M               24'h010000
`define FSP_TOP_2M             24'h03FFFF
`define FSP_Q_2M               24'h030000
`define FSP_H_2M               24'h020000
`define FSP_TOP_4M             24'h07FFFF
`define FSP_E_4M               24'h070000
`define FSP_Q_4M               24'h060000
`define FSP_H_4M               24'h040000

`endif

// ==== fsp_pkg.sv ====
package fsp_pkg;

  typedef enum logic [1:0] {
    FSP_D512K = 2'h0,
    FSP_D1M   = 2'h1,
    FSP_D2M   = 2'h2,
    FSP_D4M   = 2'h3
  } fsp_density_t;

  typedef enum logic [3:0] {
    LK_OPC   = 4'b0001,
    LK_READ  = 4'b0010,
    LK_WDATA = 4'b0100,
    LK_SKIP  = 4'b1000
  } fsp_link_st_t;

  typedef struct packed {
    logic       lock;
    logic       auto_inc;
    logic       resv;
    logic [2:0] prot;
    logic       wr_latch;
    logic       busy;
  } fsp_status_t;

  typedef struct packed {
    logic [3:0] tog;
    logic [7:0] wdata;
  } fsp_link_ev_t;

  typedef struct packed {
    logic busy;
    logic auto_inc;
    logic prog_done;
    logic sect_done;
    logic blk_done;
    logic chip_done;
    logic ai_done;
    logic ai_top;
  } fsp_engine_t;

  typedef struct packed {
    logic        valid;
    logic        chip_erase;
    logic [23:0] addr;
  } fsp_req_t;

endpackage

// ==== fsp_link.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"

module fsp_link (
  // Link pins
  input  wire logic                 i_sck,
  input  wire logic                 i_cs_n,
  input  wire logic                 i_si,
  output logic                      o_so,
  output logic                      o_so_oe,
  // System side
  input  wire logic                 i_rst,
  input  wire fsp_pkg::fsp_status_t i_status,
  output fsp_pkg::fsp_link_ev_t     o_ev
);
  import fsp_pkg::*;

  typedef struct packed {
    fsp_link_st_t st;
    logic [2:0]   bit_idx;
    logic [7:0]   op_sh;
    logic [7:0]   so_sh;
    logic         so_oe;
    fsp_status_t  stat_s1;
    fsp_status_t  stat_s2;
  } fsp_frame_t;

  localparam fsp_frame_t FR_IDLE = '{st: LK_OPC, bit_idx: 3'h0, op_sh: 8'h00,
                                     so_sh: 8'h00, so_oe: 1'b0,
                                     stat_s1: 8'h00, stat_s2: 8'h00};

  fsp_frame_t   fr_q, fr_d;
  fsp_link_ev_t ev_q, ev_d;
  logic [7:0]   sh_in;
  logic         byte_end;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    fr_d         = fr_q;
    ev_d         = ev_q;
    sh_in        = {fr_q.op_sh[6:0], i_si};
    byte_end     = (fr_q.bit_idx == 3'h7);
    fr_d.stat_s1 = i_status;
    fr_d.stat_s2 = fr_q.stat_s1;
    fr_d.bit_idx = fr_q.bit_idx + 3'h1;
    fr_d.op_sh   = sh_in;
    fr_d.so_sh   = {fr_q.so_sh[6:0], 1'b0};
    case (fr_q.st)
      LK_OPC: if (byte_end) begin
        fr_d.st = LK_SKIP;
        case (sh_in)
          `FSP_OP_STATUS_READ: begin
            fr_d.st    = LK_READ;
            fr_d.so_sh = fr_q.stat_s2;
            fr_d.so_oe = 1'b1;
          end
          `FSP_OP_WRITE_ENABLE:  ev_d.tog[`FSP_EV_WR_ENABLE] = ~ev_q.tog[`FSP_EV_WR_ENABLE];
          `FSP_OP_WRITE_DISABLE: ev_d.tog[`FSP_EV_WR_DISABLE] = ~ev_q.tog[`FSP_EV_WR_DISABLE];
          `FSP_OP_STATUS_UNLOCK: ev_d.tog[`FSP_EV_UNLOCK] = ~ev_q.tog[`FSP_EV_UNLOCK];
          `FSP_OP_STATUS_WRITE:  fr_d.st = LK_WDATA;
          default: ;
        endcase
      end
      // Fresh snapshot each byte so polling sees completion
      LK_READ: if (byte_end) begin
        fr_d.so_sh = fr_q.stat_s2;
      end
      LK_WDATA: if (byte_end) begin
        fr_d.st    = LK_SKIP;
        ev_d.wdata = sh_in;
        ev_d.tog[`FSP_EV_STAT_WRITE] = ~ev_q.tog[`FSP_EV_STAT_WRITE];
      end
      LK_SKIP: ;
      default: fr_d.st = LK_SKIP;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame state ends with chip select; event toggles must outlive frames
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      fr_q <= FR_IDLE;
    end else begin
      fr_q <= fr_d;
    end
  end

  always_ff @(posedge i_sck or posedge i_rst) begin
    if (i_rst) begin
      ev_q <= '0;
    end else begin
      ev_q <= ev_d;
    end
  end

  assign o_so    = fr_q.so_sh[7];
  assign o_so_oe = fr_q.so_oe;
  assign o_ev    = ev_q;

endmodule
`default_nettype wire

// ==== fsp_top.sv ====
// What this block does
// - Status bit 0 shows internal program or erase busy; read-only, zero at reset.
// - Status bit 1 is the write latch; program and erase refused while zero.
// - Write latch clears on reset and on a write-disable command.
// - Write latch clears on status-write commands and on program, erase completion without a same-cycle write-enable.
// - Write latch clears when auto-increment ends or hits top unprotected address without a same-cycle write-enable.
// - Status bit 6 shows auto-increment programming mode; read-only, zero at reset.
// - Status bits 2 to 4 hold protection level; writable, ones at reset.
// - Status bit 5 is reserved and always reads zero.
// - Status bit 7 is the protection lock; writable, zero at reset.
// - Status write updates level bits only if protect pin high or lock clear.
// - Protect pin low with lock set freezes lock and level bits.
// - Protect pin high makes the lock bit irrelevant to status writes.
// - Full-chip erase runs only when all three level bits are zero.
// - Program or erase inside the protected range is refused; level zero protects nothing.
// - Smallest density: levels 1, 2, 3 protect upper quarter, half, whole.
// - Second density: levels 1, 2, 3 protect upper quarter, half, whole.
// - Third density: levels 1, 2, 3 protect upper quarter, half, whole.
// - Largest density: eighth, quarter, half, then whole array for 4 to 7.
// - Status write acts only after write-enable or status-unlock command.
// - Status read repeats the register every byte until chip select rises.
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"

module fsp_top (
  // System
  input  wire logic                  I_CLK_SYS,
  input  wire logic                  I_RESET,
  input  wire logic                  I_CE_SYS,
  // Serial link
  input  wire logic                  I_SCK,
  input  wire logic                  I_CS_N,
  input  wire logic                  I_SI,
  output logic                       O_SO,
  output logic                       O_SO_OE,
  // Write-protect pin
  input  wire logic                  I_WP_N,
  // Array engine side
  input  wire fsp_pkg::fsp_engine_t  I_ENGINE,
  input  wire fsp_pkg::fsp_density_t I_DENSITY,
  input  wire fsp_pkg::fsp_req_t     I_REQ,
  output logic                       O_REQ_GRANT,
  output logic                       O_REQ_REFUSE,
  output fsp_pkg::fsp_status_t       O_STATUS
);
  import fsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic        wp_s1;
    logic        wp_s2;
    logic [3:0]  tg_s1;
    logic [3:0]  tg_s2;
    logic [3:0]  tg_seen;
    logic        wr_latch;
    logic        unlock;
    logic [2:0]  prot;
    logic        lock;
    logic        grant;
    logic        refuse;
    fsp_status_t stat;
  } fsp_sys_t;

  localparam fsp_status_t ST_RST = '{lock: `FSP_RST_LOCK, auto_inc: 1'b0, resv: 1'b0,
                                     prot: `FSP_RST_PROT, wr_latch: `FSP_RST_LATCH,
                                     busy: 1'b0};

  localparam fsp_sys_t S_RST = '{wp_s1: 1'b1, wp_s2: 1'b1, tg_s1: 4'h0, tg_s2: 4'h0,
                                 tg_seen: 4'h0, wr_latch: `FSP_RST_LATCH, unlock: 1'b0,
                                 prot: `FSP_RST_PROT, lock: `FSP_RST_LOCK, grant: 1'b0,
                                 refuse: 1'b0, stat: ST_RST};

  fsp_sys_t     s_q, s_d;
  fsp_link_ev_t link_ev;
  logic [3:0]   ev_now;
  logic         wen_ev;
  logic         latch_now;
  logic         unlock_now;
  logic         swr_take;
  logic         lock_open;
  logic         eng_clear;
  logic         hit;
  logic         req_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // Address bits above the array top are ignored
  function automatic logic prot_hit(input fsp_density_t dens, input logic [2:0] lvl,
                                    input logic [23:0] addr);
    logic [23:0] top;
    logic [23:0] base;
    logic        none;
    top  = `FSP_TOP_4M;
    base = `FSP_FULL_BASE;
    none = (lvl[1:0] == 2'h0);
    case (dens)
      FSP_D512K: begin
        top = `FSP_TOP_512K;
        case (lvl[1:0])
          2'h1:    base = `FSP_Q_512K;
          2'h2:    base = `FSP_H_512K;
          default: base = `FSP_FULL_BASE;
        endcase
      end
      FSP_D1M: begin
        top = `FSP_TOP_1M;
        case (lvl[1:0])
          2'h1:    base = `FSP_Q_1M;
          2'h2:    base = `FSP_H_1M;
          default: base = `FSP_FULL_BASE;
        endcase
      end
      FSP_D2M: begin
        top = `FSP_TOP_2M;
        case (lvl[1:0])
          2'h1:    base = `FSP_Q_2M;
          2'h2:    base = `FSP_H_2M;
          default: base = `FSP_FULL_BASE;
        endcase
      end
      FSP_D4M: begin
        top  = `FSP_TOP_4M;
        none = (lvl == `FSP_PROT_NONE);
        case (lvl)
          3'h1:    base = `FSP_E_4M;
          3'h2:    base = `FSP_Q_4M;
          3'h3:    base = `FSP_H_4M;
          default: base = `FSP_FULL_BASE;
        endcase
      end
      default: none = 1'b1;
    endcase
    prot_hit = ~none & ((addr & top) >= base);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Link end on its own clock
  fsp_link u_link (
    .i_sck    (I_SCK),
    .i_cs_n   (I_CS_N),
    .i_si     (I_SI),
    .o_so     (O_SO),
    .o_so_oe  (O_SO_OE),
    .i_rst    (I_RESET),
    .i_status (s_q.stat),
    .o_ev     (link_ev)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Write data is stable by the time its toggle clears the synchroniser
  assign ev_now     = s_q.tg_s2 ^ s_q.tg_seen;
  assign wen_ev     = ev_now[`FSP_EV_WR_ENABLE];
  assign latch_now  = s_q.wr_latch | wen_ev;
  assign unlock_now = s_q.unlock | ev_now[`FSP_EV_UNLOCK];
  assign swr_take   = ev_now[`FSP_EV_STAT_WRITE] & (latch_now | unlock_now);
  assign lock_open  = s_q.wp_s2 | ~s_q.lock;
  assign eng_clear  = I_ENGINE.prog_done | I_ENGINE.sect_done | I_ENGINE.blk_done
                    | I_ENGINE.chip_done | I_ENGINE.ai_done | I_ENGINE.ai_top;
  assign hit        = prot_hit(I_DENSITY, s_q.prot, I_REQ.addr);
  assign req_ok     = s_q.wr_latch & ~I_ENGINE.busy & ~hit
                    & (~I_REQ.chip_erase | (s_q.prot == `FSP_PROT_NONE));

  always_comb begin
    s_d         = s_q;
    s_d.wp_s1   = I_WP_N;
    s_d.wp_s2   = s_q.wp_s1;
    s_d.tg_s1   = link_ev.tog;
    s_d.tg_s2   = s_q.tg_s1;
    s_d.tg_seen = s_q.tg_s2;
    if (wen_ev) begin
      s_d.wr_latch = 1'b1;
    end
    // A fresh write-enable beats a completion in the same cycle
    if (eng_clear & ~wen_ev) begin
      s_d.wr_latch = 1'b0;
    end
    if (ev_now[`FSP_EV_UNLOCK]) begin
      s_d.unlock = 1'b1;
    end
    if (ev_now[`FSP_EV_WR_DISABLE]) begin
      s_d.wr_latch = 1'b0;
    end
    if (swr_take) begin
      s_d.wr_latch = 1'b0;
      s_d.unlock   = 1'b0;
      if (lock_open) begin
        s_d.prot = link_ev.wdata[`FSP_BIT_PROT_HI:`FSP_BIT_PROT_LO];
        s_d.lock = link_ev.wdata[`FSP_BIT_LOCK];
      end
    end
    s_d.grant  = I_REQ.valid & req_ok;
    s_d.refuse = I_REQ.valid & ~req_ok;
    s_d.stat   = '{lock: s_d.lock, auto_inc: I_ENGINE.auto_inc,
                   resv: 1'b0, prot: s_d.prot, wr_latch: s_d.wr_latch,
                   busy: I_ENGINE.busy};
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      s_q <= S_RST;
    end else if (I_CE_SYS) begin
      s_q <= s_d;
    end
  end

  assign O_REQ_GRANT  = s_q.grant;
  assign O_REQ_REFUSE = s_q.refuse;
  assign O_STATUS     = s_q.stat;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  logic adv;
  assign adv = I_CE_SYS & ~I_RESET;

  default clocking cb_sys @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);

  property p_busy_mirror;
    $past(adv) |-> O_STATUS.busy == $past(I_ENGINE.busy);
  endproperty
  a_busy_mirror: assert property (p_busy_mirror)
    else $error("busy bit does not follow engine");

  property p_auto_mirror;
    $past(adv) |-> O_STATUS.auto_inc == $past(I_ENGINE.auto_inc);
  endproperty
  a_auto_mirror: assert property (p_auto_mirror)
    else $error("auto-increment bit does not follow engine");

  property p_resv_zero;
    O_STATUS.resv == 1'b0;
  endproperty
  a_resv_zero: assert property (p_resv_zero)
    else $error("reserved bit not zero");

  property p_reset_vals;
    $past(I_RESET) |-> O_STATUS.prot == `FSP_RST_PROT && !O_STATUS.lock && !O_STATUS.wr_latch;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("status not at reset values");

  property p_refuse_no_latch;
    adv && I_REQ.valid && !s_q.wr_latch |=> O_REQ_REFUSE && !O_REQ_GRANT;
  endproperty
  a_refuse_no_latch: assert property (p_refuse_no_latch)
    else $error("request taken with latch clear");

  property p_disable_clears;
    adv && ev_now[`FSP_EV_WR_DISABLE] |=> !O_STATUS.wr_latch;
  endproperty
  a_disable_clears: assert property (p_disable_clears)
    else $error("write-disable left latch set");

  property p_engine_clears;
    adv && eng_clear && !wen_ev |=> !s_q.wr_latch ##1 !O_STATUS.wr_latch || $past(wen_ev);
  endproperty
  a_engine_clears: assert property (p_engine_clears)
    else $error("completion left latch set");

  property p_auto_end_clears;
    adv && (I_ENGINE.ai_done || I_ENGINE.ai_top) && !wen_ev |=> !s_q.wr_latch;
  endproperty
  a_auto_end_clears: assert property (p_auto_end_clears)
    else $error("auto-increment end left latch set");

  property p_locked_hold;
    adv && !s_q.wp_s2 && s_q.lock |=> $stable(s_q.prot) && $stable(s_q.lock);
  endproperty
  a_locked_hold: assert property (p_locked_hold)
    else $error("locked level bits changed");

  property p_write_lands;
    adv && swr_take && lock_open |=> O_STATUS.prot == $past(link_ev.wdata[4:2]);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("allowed status write lost");

  property p_write_needs_enable;
    adv && !swr_take |=> $stable(s_q.prot) && $stable(s_q.lock);
  endproperty
  a_write_needs_enable: assert property (p_write_needs_enable)
    else $error("level bits changed without enabled write");

  property p_chip_guard;
    adv && I_REQ.valid && I_REQ.chip_erase && s_q.prot != `FSP_PROT_NONE |=> O_REQ_REFUSE;
  endproperty
  a_chip_guard: assert property (p_chip_guard)
    else $error("chip erase taken while protected");

  property p_range_guard;
    adv && I_REQ.valid && hit |=> O_REQ_REFUSE;
  endproperty
  a_range_guard: assert property (p_range_guard)
    else $error("protected address taken");

  property p_full_small;
    adv && I_REQ.valid && I_DENSITY != FSP_D4M && s_q.prot[1:0] == 2'h3 |=> O_REQ_REFUSE;
  endproperty
  a_full_small: assert property (p_full_small)
    else $error("full level not protecting small array");

  property p_full_large;
    adv && I_REQ.valid && I_DENSITY == FSP_D4M && s_q.prot[2] |=> O_REQ_REFUSE;
  endproperty
  a_full_large: assert property (p_full_large)
    else $error("full level not protecting large array");

  property p_swr_clears;
    adv && swr_take |=> !O_STATUS.wr_latch;
  endproperty
  a_swr_clears: assert property (p_swr_clears)
    else $error("status write left latch set");

  property p_pin_high_open;
    adv && swr_take && s_q.wp_s2 |=> O_STATUS.lock == $past(link_ev.wdata[`FSP_BIT_LOCK]);
  endproperty
  a_pin_high_open: assert property (p_pin_high_open)
    else $error("status write blocked with protect pin high");

  property p_latch_set_only;
    adv && !wen_ev |=> !$rose(O_STATUS.wr_latch);
  endproperty
  a_latch_set_only: assert property (p_latch_set_only)
    else $error("latch set without write-enable");

  property p_busy_refuse;
    adv && I_REQ.valid && I_ENGINE.busy |=> O_REQ_REFUSE && !O_REQ_GRANT;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse)
    else $error("request taken while busy");

  // Clock enable low must hold every output registered on the system clock
  property p_ce_freeze;
    !I_CE_SYS |=> $stable(O_STATUS) && $stable(O_REQ_GRANT) && $stable(O_REQ_REFUSE);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("state moved with clock enable low");

  c_status_write: cover property (adv && swr_take && lock_open);
  c_locked_write: cover property (adv && swr_take && !lock_open);
  c_grant:        cover property (O_REQ_GRANT);
  c_chip_refused: cover property (adv && I_REQ.valid && I_REQ.chip_erase ##1 O_REQ_REFUSE);
  c_ce_hold:      cover property (!I_CE_SYS && I_ENGINE.prog_done);

endmodule
`default_nettype wire

// ==== fsp_host.sv ====
`timescale 1ns/1ps
`default_nettype none

module fsp_host (
  // Link pins
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si,
  input  wire logic i_so,
  input  wire logic i_so_oe
);
  initial begin
    o_sck  = 1'b0;
    o_si   = 1'b0;
    // Late edge so the frame logic sees a real deselect
    #1 o_cs_n = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One frame, mode 0, 6 ns clock that stands still outside the frame
  task automatic frame(input logic [7:0] op, input logic [7:0] dat, input int n,
                       output logic [15:0] rd);
    logic [7:0] b;
    rd = 16'hXXXX;
    #1.7;
    o_cs_n = 1'b0;
    for (int k = 0; k < n; k++) begin
      b = (k == 0) ? op : dat;
      for (int i = 7; i >= 0; i--) begin
        o_si = b[i];
        #3;
        // Sampled just ahead of the rising edge; undriven must never pass
        rd = {rd[14:0], i_so_oe ? i_so : 1'bx};
        o_sck = 1'b1;
        #3 o_sck = 1'b0;
      end
    end
    #3 o_cs_n = 1'b1;
    // Released line shows the inverse, not a stale bit
    o_si = ~o_si;
  endtask
endmodule

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"

module tb;
  import fsp_pkg::*;

  typedef struct packed {
    fsp_density_t dens;
    logic [2:0]   prot;
    logic         chip;
    logic [23:0]  addr;
    logic         grant;
  } fsp_row_t;

  logic         clk;
  logic         rst;
  logic         ce;
  logic         wp_n;
  fsp_density_t dens;
  fsp_engine_t  eng;
  fsp_req_t     req;
  logic         sck;
  logic         cs_n;
  logic         si;
  logic         so;
  logic         so_oe;
  logic         grant;
  logic         refuse;
  fsp_status_t  st;
  logic [15:0]  rd;
  int           miscompares;
  int           comparisons;

  localparam fsp_row_t ROWS [19] = '{
    '{FSP_D512K, 3'h1, 1'b0, 24'h00BFFF, 1'b1}, '{FSP_D512K, 3'h1, 1'b0, 24'h00C000, 1'b0},
    '{FSP_D512K, 3'h2, 1'b0, 24'h007FFF, 1'b1}, '{FSP_D512K, 3'h2, 1'b0, 24'h008000, 1'b0},
    '{FSP_D512K, 3'h4, 1'b0, 24'h00FFFF, 1'b1}, '{FSP_D512K, 3'h4, 1'b1, 24'h000000, 1'b0},
    '{FSP_D1M, 3'h1, 1'b0, 24'h017FFF, 1'b1}, '{FSP_D1M, 3'h1, 1'b0, 24'h018000, 1'b0},
    '{FSP_D1M, 3'h3, 1'b0, 24'h000000, 1'b0}, '{FSP_D2M, 3'h2, 1'b0, 24'h01FFFF, 1'b1},
    '{FSP_D2M, 3'h2, 1'b0, 24'h020000, 1'b0}, '{FSP_D2M, 3'h0, 1'b1, 24'h000000, 1'b1},
    '{FSP_D4M, 3'h1, 1'b0, 24'h06FFFF, 1'b1}, '{FSP_D4M, 3'h1, 1'b0, 24'h070000, 1'b0},
    '{FSP_D4M, 3'h2, 1'b0, 24'h05FFFF, 1'b1}, '{FSP_D4M, 3'h2, 1'b0, 24'h060000, 1'b0},
    '{FSP_D4M, 3'h3, 1'b0, 24'h03FFFF, 1'b1}, '{FSP_D4M, 3'h3, 1'b0, 24'h040000, 1'b0},
    '{FSP_D4M, 3'h5, 1'b0, 24'h000000, 1'b0}
  };

  fsp_top i_dut (
    .I_CLK_SYS    (clk),
    .I_RESET      (rst),
    .I_CE_SYS     (ce),
    .I_SCK        (sck),
    .I_CS_N       (cs_n),
    .I_SI         (si),
    .O_SO         (so),
    .O_SO_OE      (so_oe),
    .I_WP_N       (wp_n),
    .I_ENGINE     (eng),
    .I_DENSITY    (dens),
    .I_REQ        (req),
    .O_REQ_GRANT  (grant),
    .O_REQ_REFUSE (refuse),
    .O_STATUS     (st)
  );

  fsp_host i_host (
    .o_sck   (sck),
    .o_cs_n  (cs_n),
    .o_si    (si),
    .i_so    (so),
    .i_so_oe (so_oe)
  );

  always #20 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic final_report();
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Link and request helpers
  task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input int n);
    i_host.frame(op, dat, n, rd);
    // Events land 2 to 3 cycles later; 8 keeps same-kind spacing too
    repeat (8) @(negedge clk);
  endtask

  task automatic wsr(input logic [7:0] dat);
    cmd(`FSP_OP_WRITE_ENABLE, 8'h00, 1);
    cmd(`FSP_OP_STATUS_WRITE, dat, 2);
  endtask

  task automatic rsr(input logic [7:0] exp);
    cmd(`FSP_OP_STATUS_READ, 8'h00, 3);
    chk8("link status", exp, rd[15:8]);
    chk8("link status repeat", exp, rd[7:0]);
    chk8("status port", exp, st);
    chk1("output enable idle", 1'b0, so_oe);
  endtask

  task automatic ask(input logic chip, input logic [23:0] addr, input logic exp);
    req = '{valid: 1'b1, chip_erase: chip, addr: addr};
    @(negedge clk);
    req.valid = 1'b0;
    chk1("grant", exp, grant);
    chk1("refuse", ~exp, refuse);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    final_report();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b0;
    ce = 1'b1;
    wp_n = 1'b1;
    dens = FSP_D512K;
    eng = '0;
    req = '0;
    miscompares = 0;
    comparisons = 0;
    // Late edge so the link's asynchronous reset is seen
    #1 rst = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    chk8("status after reset", 8'h1C, st);
    rsr(8'h1C);
    ask(1'b0, 24'h000000, 1'b0);
    cmd(`FSP_OP_STATUS_WRITE, 8'h00, 2);
    rsr(8'h1C);
    cmd(`FSP_OP_STATUS_UNLOCK, 8'h00, 1);
    cmd(`FSP_OP_STATUS_WRITE, 8'h00, 2);
    rsr(8'h00);
    cmd(`FSP_OP_WRITE_ENABLE, 8'h00, 1);
    rsr(8'h02);
    cmd(`FSP_OP_WRITE_DISABLE, 8'h00, 1);
    rsr(8'h00);
    // Unknown opcode skips the rest of the frame
    cmd(8'hFF, `FSP_OP_WRITE_ENABLE, 2);
    rsr(8'h00);
    // Every completion pulse drops the latch
    for (int k = 0; k < 6; k++) begin
      cmd(`FSP_OP_WRITE_ENABLE, 8'h00, 1);
      chk1("latch set", 1'b1, st.wr_latch);
      eng = fsp_engine_t'(8'h01 << k);
      @(negedge clk);
      eng = '0;
      repeat (2) @(negedge clk);
      chk1("latch after completion", 1'b0, st.wr_latch);
    end
    cmd(`FSP_OP_WRITE_ENABLE, 8'h00, 1);
    eng.busy = 1'b1;
    eng.auto_inc = 1'b1;
    repeat (2) @(negedge clk);
    rsr(8'h43);
    ask(1'b0, 24'h000000, 1'b0);
    eng = '0;
    repeat (2) @(negedge clk);
    ask(1'b0, 24'h00FFFF, 1'b1);
    ask(1'b1, 24'h000000, 1'b1);
    // Read-only bits set in the written byte must not stick
    foreach (ROWS[r]) begin
      dens = ROWS[r].dens;
      wsr({3'b011, ROWS[r].prot, 2'b11});
      rsr({3'b000, ROWS[r].prot, 2'b00});
      cmd(`FSP_OP_WRITE_ENABLE, 8'h00, 1);
      ask(ROWS[r].chip, ROWS[r].addr, ROWS[r].grant);
    end
    wp_n = 1'b0;
    repeat (4) @(negedge clk);
    wsr(8'h8C);
    rsr(8'h8C);
    wsr(8'h00);
    rsr(8'h8C);
    wp_n = 1'b1;
    repeat (4) @(negedge clk);
    wsr(8'h00);
    rsr(8'h00);
    cmd(`FSP_OP_WRITE_ENABLE, 8'h00, 1);
    // Completion pulse while frozen is never taken
    ce = 1'b0;
    eng.prog_done = 1'b1;
    repeat (2) @(negedge clk);
    eng = '0;
    ce = 1'b1;
    @(negedge clk);
    chk1("latch frozen", 1'b1, st.wr_latch);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk8("status after second reset", 8'h1C, st);
    final_report();
  end
endmodule

`default_nettype wire
